// *** rtl/hdv_defines.svh ***
// Constants for the HD video timing reference generator: offsets, fields, levels, counts.
// Assumes a single luminance-rate clock and inclusion by its bare name.
//
// How it works
// R1: Every sample is an 8 or 10 bit word.
// R2: Video words are clipped to 1.00 through 254.75.
// R3: 8-bit words get two zero LSBs appended.
// R4: 8-bit mode uses only bits 9 to 2.
// R5: Chroma at half rate, co-sited with first Y.
// R6: Line length 2200, 2640 or 2750 clocks.
// R7: Line blanking 280, 720 or 830 clocks, EAV to SAV.
// R8: Active line is exactly 1920 samples.
// R9: SAV, active samples and EAV span 1928 clocks.
// R10: EAV and SAV are four words each.
// R11: Line starts with EAV; reference 192 before SAV end.
// R12: SAV and EAV are sent on every line.
// R13: F and V change only at EAV.
// R14: Fourth word carries protection bits for the receiver.
// R15: Interlace V low on lines 21-560 and 584-1123.
// R16: Lines 1-563 field one, 564-1125 field two.
// R17: Preamble ones, zeros, zeros; then 1 F V H P.
// R18: Protection bits are XORs of F, V and H.
// R19: Progressive F zero, V low on lines 42-1121.
// R20: 20-bit words pair Y with alternating Cb and Cr.
// R21: Sample count clears on EAV; line count advances too.
// R22: Blanking words hold black and achromatic levels.
`ifndef HDV_DEFINES_SVH
`define HDV_DEFINES_SVH

`define HDV_CTRL_OFS    12'h000
`define HDV_STAT_OFS    12'h004
`define HDV_POS_OFS     12'h008

`define HDV_CTRL_EN     0
`define HDV_CTRL_W8     1
`define HDV_CTRL_FAM    2
`define HDV_CTRL_PROG   4
`define HDV_CTRL_RST    5'h00
`define HDV_STAT_F      16
`define HDV_STAT_V      17
`define HDV_STAT_RUN    18

`define HDV_LEN_60      12'h898
`define HDV_LEN_50      12'hA50
`define HDV_LEN_24      12'hABE
`define HDV_BLANK_60    12'h118
`define HDV_BLANK_50    12'h2D0
`define HDV_BLANK_24    12'h33E
`define HDV_HREF_60     12'h058
`define HDV_HREF_50     12'h210
`define HDV_HREF_24     12'h27E
`define HDV_TRS_LEN     12'h004
`define HDV_ACTIVE      12'h780

`define HDV_LINES       11'h465
`define HDV_I_ACT1_FIRST 11'h015
`define HDV_I_ACT1_LAST  11'h230
`define HDV_I_FIELD2     11'h234
`define HDV_I_ACT2_FIRST 11'h248
`define HDV_I_ACT2_LAST  11'h463
`define HDV_P_ACT_FIRST  11'h02A
`define HDV_P_ACT_LAST   11'h461

`define HDV_LVL_BLACK   10'h040
`define HDV_LVL_ACHRO   10'h200
`define HDV_LVL_MIN     10'h004
`define HDV_LVL_MAX10   10'h3FB
`define HDV_LVL_MAX8    10'h3F8
`define HDV_LVL_ONES    10'h3FF
`define HDV_MASK8       10'h3FC

`endif

// *** rtl/hdv_pkg.sv ***
// Types shared by the HD video timing reference generator.
// Assumes the constants header is compiled alongside.
package hdv_pkg;
   typedef enum logic [1:0] {
      HDV_FAM_60 = 2'h0,
      HDV_FAM_50 = 2'h1,
      HDV_FAM_24 = 2'h2
   } hdv_fam_t;

   typedef enum logic [3:0] {
      HDV_ST_EAV    = 4'h1,
      HDV_ST_HBLANK = 4'h2,
      HDV_ST_SAV    = 4'h4,
      HDV_ST_ACTIVE = 4'h8
   } hdv_state_t;
endpackage

// *** rtl/hdv_trs_word.sv ***
// Fourth word of a timing reference code, built from the F, V and H flags.
// Assumes the caller places the fixed preamble words itself.
`timescale 1ns/1ns
module hdv_trs_word (
   input  wire logic       f,
   input  wire logic       v,
   input  wire logic       h,
   output      logic [9:0] word
);
   wire logic [3:0] prot;

   assign prot[3] = v ^ h;     // R18
   assign prot[2] = f ^ h;     // R18
   assign prot[1] = f ^ v;     // R18
   assign prot[0] = f ^ v ^ h; // R18
   // The two fixed low zeros keep the word valid in 8-bit mode as well.
   assign word = {1'b1, f, v, h, prot, 2'b00}; // R17
endmodule

// *** rtl/hdv_line_ctr.sv ***
// Line counter with the F and V flags that belong to the current digital line.
// Assumes adv pulses once per line, at the edge where the sample count wraps.
`include "hdv_defines.svh"
`timescale 1ns/1ns
module hdv_line_ctr (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        run,
   input  wire logic        adv,
   input  wire logic        prog,
   output      logic [10:0] line_r,
   output      logic        f_r,
   output      logic        v_r
);
   wire logic [10:0] line_nxt;
   wire logic        i_act;
   wire logic        p_act;
   wire logic        f_nxt;
   wire logic        v_nxt;

   assign line_nxt = (!run || line_r == `HDV_LINES) ? 11'h001 : line_r + 11'h001;
   assign i_act = (line_nxt >= `HDV_I_ACT1_FIRST && line_nxt <= `HDV_I_ACT1_LAST) ||
                  (line_nxt >= `HDV_I_ACT2_FIRST && line_nxt <= `HDV_I_ACT2_LAST); // R15
   assign p_act = line_nxt >= `HDV_P_ACT_FIRST && line_nxt <= `HDV_P_ACT_LAST;    // R19
   assign f_nxt = !prog && line_nxt >= `HDV_I_FIELD2; // R16 R19
   assign v_nxt = prog ? !p_act : !i_act;

   // Flags are only reloaded with the line number, so while running they move at EAV alone.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_r <= 11'h001;
         f_r    <= 1'b0;
         v_r    <= 1'b1;
      end else if (ce && (adv || !run)) begin
         line_r <= line_nxt; // R21
         f_r    <= f_nxt;    // R13
         v_r    <= v_nxt;    // R13
      end
   end
endmodule

// *** rtl/hdv_timing_gen.sv ***
// Top of the HD video timing reference generator: APB registers, line timing and
// the 20-bit luminance/colour-difference word stream framed by EAV and SAV.
// Assumes pix_y and pix_c come from logic on pclk and are valid whenever pix_take is high.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`include "hdv_defines.svh"
`timescale 1ns/1ns
module hdv_timing_gen (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic [9:0]  pix_y,
   input  wire logic [9:0]  pix_c,
   output      logic        pix_take,
   output      logic        pix_cr,
   output      logic [9:0]  out_y,
   output      logic [9:0]  out_c,
   output      logic        out_de,
   output      logic        out_eav,
   output      logic        out_href
);
   // Register map, one aligned word each.
   // CTRL holds enable in bit 0, 8-bit words in bit 1, the family in bits 3:2, progressive in bit 4.
   // STAT shows the line number in bits 10:0, F in bit 16, V in bit 17 and running in bit 18.
   // POS shows the sample count in bits 11:0, which is zero at the first EAV word.
   // Family 0 is 60/30 Hz, 1 is 50/25 Hz and 2 is 24 Hz; code 3 runs as family 0.

   // Software control word and the copy that the timing logic actually uses.
   logic [4:0]  ctrl_r;
   logic [4:0]  act_r;
   logic [4:0]  act_nxt;

   // APB answer registers.
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;

   // Horizontal timing.
   logic [11:0] hcnt_r;
   logic [11:0] hcnt_nxt;
   hdv_pkg::hdv_state_t state_r;
   hdv_pkg::hdv_state_t state_nxt;

   // Output stream registers.
   logic [9:0]  y_r;
   logic [9:0]  y_nxt;
   logic [9:0]  c_r;
   logic [9:0]  c_nxt;
   logic        de_r;
   logic        eav_r;
   logic        href_r;
   logic        take_r;
   logic        cr_r;

   // Line counter outputs.
   wire logic [10:0] line;
   wire logic        fld_f;
   wire logic        fld_v;

   // Configuration decode.
   wire logic        run;
   wire logic        w8;
   wire logic        prog;
   wire hdv_pkg::hdv_fam_t fam;
   wire logic [11:0] len;
   wire logic [11:0] blank;
   wire logic [11:0] href_pos;
   wire logic [11:0] sav_start;
   wire logic        wrap;

   assign run  = act_r[`HDV_CTRL_EN];
   assign w8   = act_r[`HDV_CTRL_W8]; // R1
   // The line counter works out the flags of the coming line, so it must see the mode
   // that this line will run in, not the one that is ending.
   assign prog = act_nxt[`HDV_CTRL_PROG];
   assign fam  = hdv_pkg::hdv_fam_t'(act_r[`HDV_CTRL_FAM +: 2]);

   // An unused family code falls back to the 60/30 Hz timing.
   assign len = (fam == hdv_pkg::HDV_FAM_50) ? `HDV_LEN_50 :
                (fam == hdv_pkg::HDV_FAM_24) ? `HDV_LEN_24 : `HDV_LEN_60; // R6
   assign blank = (fam == hdv_pkg::HDV_FAM_50) ? `HDV_BLANK_50 :
                  (fam == hdv_pkg::HDV_FAM_24) ? `HDV_BLANK_24 : `HDV_BLANK_60; // R7
   assign href_pos = (fam == hdv_pkg::HDV_FAM_50) ? `HDV_HREF_50 :
                     (fam == hdv_pkg::HDV_FAM_24) ? `HDV_HREF_24 : `HDV_HREF_60; // R11
   assign sav_start = blank - `HDV_TRS_LEN;
   assign wrap      = run && hcnt_r == len - 12'h001;

   // APB decode.
   wire logic        acc;
   wire logic        done;
   wire logic        first_acc;
   wire logic [31:0] ctrl_word;
   wire logic [31:0] stat_word;
   wire logic [31:0] pos_word;
   wire logic        sel_ctrl;
   wire logic        sel_stat;
   wire logic        sel_pos;
   wire logic        mapped;
   wire logic [31:0] rd_mux;

   assign acc      = psel && penable;
   assign done     = acc && pready_r;
   assign sel_ctrl = paddr == `HDV_CTRL_OFS;
   assign sel_stat = paddr == `HDV_STAT_OFS;
   assign sel_pos  = paddr == `HDV_POS_OFS;
   assign mapped   = sel_ctrl || sel_stat || sel_pos;
   assign first_acc = acc && !pready_r;
   assign ctrl_word = {27'h000_0000, ctrl_r};
   assign stat_word = {13'h0000, run, fld_v, fld_f, 5'h00, line};
   assign pos_word  = {20'h0_0000, hcnt_r};
   assign rd_mux    = sel_ctrl ? ctrl_word :
                      sel_stat ? stat_word :
                      sel_pos  ? pos_word : 32'h0000_0000;

   // One wait state: pready rises in the second access cycle and the write lands there.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (ce) begin
         pready_r  <= first_acc;
         prdata_r  <= (first_acc && !pwrite) ? rd_mux : 32'h0000_0000;
         pslverr_r <= first_acc && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `HDV_CTRL_RST;
      end else if (ce && done && pwrite && sel_ctrl) begin
         ctrl_r <= pwdata[4:0];
      end
   end

   // While running, settings are adopted only at a line boundary so that no line is ever cut short.
   // A stop waits one step longer, for the EAV that closes the last data block, so a
   // receiver never sees a block without its end code. The price is that a new
   // setting lags the write by up to one line.
   wire logic        stop_req;
   wire logic        eav_last;
   wire logic        adopt;

   assign stop_req = !ctrl_r[`HDV_CTRL_EN];
   assign eav_last = state_r == hdv_pkg::HDV_ST_EAV && hcnt_r == `HDV_TRS_LEN - 12'h001;
   assign adopt    = !run || (wrap && !stop_req) || (eav_last && stop_req); // R12
   assign act_nxt  = adopt ? ctrl_r : act_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_r <= `HDV_CTRL_RST;
      end else if (ce) begin
         act_r <= act_nxt;
      end
   end

   // Horizontal counter: sample 0 is the first EAV word. A line runs EAV in samples 0 to 3,
   // blanking words up to sav_start - 1, SAV up to blank - 1, then active samples to len - 1.
   assign hcnt_nxt = (!run || wrap) ? 12'h000 : hcnt_r + 12'h001; // R21

   always_comb begin
      state_nxt = state_r;
      if (!run) begin
         state_nxt = hdv_pkg::HDV_ST_EAV;
      end else begin
         case (state_r)
            hdv_pkg::HDV_ST_EAV: begin
               if (hcnt_r == `HDV_TRS_LEN - 12'h001) begin // R10
                  state_nxt = hdv_pkg::HDV_ST_HBLANK;
               end
            end
            hdv_pkg::HDV_ST_HBLANK: begin
               if (hcnt_r == sav_start - 12'h001) begin
                  state_nxt = hdv_pkg::HDV_ST_SAV;
               end
            end
            hdv_pkg::HDV_ST_SAV: begin
               if (hcnt_r == blank - 12'h001) begin // R12
                  state_nxt = hdv_pkg::HDV_ST_ACTIVE;
               end
            end
            hdv_pkg::HDV_ST_ACTIVE: begin
               if (wrap) begin // R8 R9
                  state_nxt = hdv_pkg::HDV_ST_EAV;
               end
            end
            default: begin
               state_nxt = hdv_pkg::HDV_ST_EAV;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcnt_r  <= 12'h000;
         state_r <= hdv_pkg::HDV_ST_EAV;
      end else if (ce) begin
         hcnt_r  <= hcnt_nxt;
         state_r <= state_nxt;
      end
   end

   hdv_line_ctr u_line (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .run     (run),
      .adv     (wrap),
      .prog    (prog),
      .line_r  (line),
      .f_r     (fld_f),
      .v_r     (fld_v)
   );

   // Timing reference words.
   wire logic       in_eav;
   wire logic       in_sav;
   wire logic [1:0] trs_idx;
   wire logic [11:0] sav_off;
   wire logic [11:0] px_nxt;
   wire logic [9:0] flag_word;
   wire logic [9:0] ones_word;
   wire logic [9:0] trs_word;

   assign in_eav    = run && state_r == hdv_pkg::HDV_ST_EAV;
   assign in_sav    = run && state_r == hdv_pkg::HDV_ST_SAV;
   assign sav_off   = hcnt_r - sav_start;
   assign trs_idx   = in_eav ? hcnt_r[1:0] : sav_off[1:0];
   assign ones_word = w8 ? `HDV_MASK8 : `HDV_LVL_ONES; // R4

   hdv_trs_word u_trs (
      .f    (fld_f),
      .v    (fld_v),
      .h    (in_eav),
      .word (flag_word)
   ); // R14

   assign trs_word = (trs_idx == 2'h0) ? ones_word :
                     (trs_idx == 2'h3) ? flag_word : 10'h000; // R17

   // Clip incoming video away from the reserved code levels.
   function automatic logic [9:0] clip(input logic [9:0] d, input logic narrow);
      logic [9:0] m;
      logic [9:0] hi;
      m  = narrow ? (d & `HDV_MASK8) : d; // R3
      hi = narrow ? `HDV_LVL_MAX8 : `HDV_LVL_MAX10;
      if (m < `HDV_LVL_MIN) begin
         clip = `HDV_LVL_MIN;
      end else if (m > hi) begin
         clip = hi;
      end else begin
         clip = m;
      end
   endfunction

   // Active sample index of the coming clock; even indices carry Cb, odd ones Cr.
   assign px_nxt = hcnt_nxt - blank;

   always_comb begin
      y_nxt = `HDV_LVL_BLACK; // R22
      c_nxt = `HDV_LVL_ACHRO; // R22
      if (in_eav || in_sav) begin
         y_nxt = trs_word; // R12
         c_nxt = trs_word;
      end else if (run && state_r == hdv_pkg::HDV_ST_ACTIVE) begin
         y_nxt = clip(pix_y, w8); // R2
         c_nxt = clip(pix_c, w8); // R2 R5
      end
   end

   // All stream outputs lag the counter by one clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         y_r    <= `HDV_LVL_BLACK;
         c_r    <= `HDV_LVL_ACHRO;
         de_r   <= 1'b0;
         eav_r  <= 1'b0;
         href_r <= 1'b0;
      end else if (ce) begin
         y_r    <= y_nxt;
         c_r    <= c_nxt;
         de_r   <= run && state_r == hdv_pkg::HDV_ST_ACTIVE; // R8
         eav_r  <= in_eav && hcnt_r == 12'h000;              // R11
         href_r <= run && hcnt_r == href_pos;                 // R11
      end
   end

   // The source is told, in the same clock that a sample is taken, that it is taken and whether it is Cb or Cr.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         take_r <= 1'b0;
         cr_r   <= 1'b0;
      end else if (ce) begin
         take_r <= state_nxt == hdv_pkg::HDV_ST_ACTIVE && run;
         cr_r   <= px_nxt[0]; // R20
      end
   end

   assign prdata   = prdata_r;
   assign pready   = pready_r;
   assign pslverr  = pslverr_r;
   assign pix_take = take_r;
   assign pix_cr   = cr_r;
   assign out_y    = y_r;
   assign out_c    = c_r;
   assign out_de   = de_r;
   assign out_eav  = eav_r;
   assign out_href = href_r;
endmodule

// *** dv/hdv_timing_monitor.sv ***
// Assertions on the video stream outputs of the timing generator.
// Assumes it is bound to hdv_timing_gen and that ce stays high.
`include "hdv_defines.svh"
`timescale 1ns/1ns
module hdv_timing_monitor (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic [9:0] out_y,
   input wire logic [9:0] out_c,
   input wire logic       out_de,
   input wire logic       out_eav,
   input wire logic       out_href,
   input wire logic       pix_take
);
   logic [11:0] hpos_r;
   logic [11:0] run_r;
   logic [1:0]  fv_r;
   logic        seen_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hpos_r <= 12'h000;
         run_r  <= 12'h000;
         fv_r   <= 2'h0;
         seen_r <= 1'b0;
      end else begin
         hpos_r <= out_eav ? 12'h001 : hpos_r + 12'h001;
         run_r  <= out_de ? run_r + 12'h001 : 12'h000;
         seen_r <= seen_r | out_eav;
         if (hpos_r == 12'h003) begin
            fv_r <= out_y[8:7];
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_preamble;
      out_y[9:2] == 8'hFF ##1 out_y == 10'h000 ##1 out_y == 10'h000;
   endsequence
   sequence s_flag_word;
      out_y[9] && out_y[6] && out_y[1:0] == 2'h0;
   endsequence
   a_eav_words: assert property (out_eav |-> s_preamble ##1 s_flag_word)
      else $error("eav code words wrong");
   a_prot_bits: assert property (out_eav |-> ##3 (out_y[5] == (out_y[7] ^ out_y[6])) &&
      (out_y[4] == (out_y[8] ^ out_y[6])) && (out_y[3] == (out_y[8] ^ out_y[7])) &&
      (out_y[2] == (^out_y[8:6]))) else $error("protection bits wrong");
   a_active_len: assert property ($fell(out_de) |-> run_r == `HDV_ACTIVE)
      else $error("active line length wrong");
   a_eav_follows: assert property ($fell(out_de) |-> out_eav)
      else $error("eav does not follow active samples");
   a_sav_precedes: assert property ($rose(out_de) |->
      $past(out_y[9]) && !$past(out_y[6]) && $past(out_y[8:7]) == fv_r)
      else $error("sav word wrong before active samples");
   a_href_pos: assert property (out_href |-> hpos_r == `HDV_HREF_60 ||
      hpos_r == `HDV_HREF_50 || hpos_r == `HDV_HREF_24) else $error("reference misplaced");
   a_href_lead: assert property (out_href |-> ##191 !out_de ##1 out_de)
      else $error("active start not 192 after reference");
   a_line_len: assert property (out_eav && seen_r |-> hpos_r == `HDV_LEN_60 ||
      hpos_r == `HDV_LEN_50 || hpos_r == `HDV_LEN_24) else $error("line length wrong");
   a_video_range: assert property (out_de |-> out_y inside {[10'h004:10'h3FB]} &&
      out_c inside {[10'h004:10'h3FB]}) else $error("reserved level in video");
   a_take_de: assert property (pix_take |=> out_de)
      else $error("taken sample not output");
endmodule
bind hdv_timing_gen hdv_timing_monitor u_hdv_timing_monitor (.pclk(pclk), .presetn(presetn),
   .out_y(out_y), .out_c(out_c), .out_de(out_de), .out_eav(out_eav), .out_href(out_href),
   .pix_take(pix_take));

// *** dv/hdv_rx_model.sv ***
// Destination receiver model: decodes the flag word and measures line and active length.
// Assumes the stream comes from the generator on the same clock.
`timescale 1ns/1ns
module hdv_rx_model (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [9:0]  out_y,
   input wire logic        out_de,
   input wire logic        out_eav,
   output     logic [2:0]  eav_fvh,
   output     logic [11:0] line_len,
   output     logic [11:0] act_len,
   output     logic        prot_bad
);
   logic [11:0] cnt_r;
   logic [11:0] act_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r    <= 12'h000;
         act_r    <= 12'h000;
         eav_fvh  <= 3'h0;
         line_len <= 12'h000;
         act_len  <= 12'h000;
         prot_bad <= 1'b0;
      end else begin
         cnt_r <= out_eav ? 12'h001 : cnt_r + 12'h001;
         act_r <= out_de ? act_r + 12'h001 : 12'h000;
         if (out_eav) begin
            line_len <= cnt_r;
         end
         if (!out_de && act_r != 12'h000) begin
            act_len <= act_r;
         end
         // Only bits 8 to 2 are decoded, so an 8-bit source reads the same.
         if (cnt_r == 12'h003) begin
            eav_fvh  <= out_y[8:6];
            prot_bad <= out_y[5:2] != {out_y[7] ^ out_y[6], out_y[8] ^ out_y[6],
                                       out_y[8] ^ out_y[7], ^out_y[8:6]};
         end
      end
   end
endmodule

// *** dv/hd_video_timing_ref_generator_tb.sv ***
// Self-checking bench for the timing generator: APB set-up, then lines of each family.
// Assumes the monitor is bound by its own file and the receiver model sits on the stream.
`include "hdv_defines.svh"
`timescale 1ns/1ns
module hd_video_timing_ref_generator_tb;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic pix_take, pix_cr, out_de, out_eav, out_href, prot_bad;
   logic [11:0] paddr, line_len, act_len;
   logic [31:0] pwdata, prdata, q;
   logic [9:0] pix_y, pix_c, out_y, out_c;
   logic [2:0] eav_fvh;
   logic e;
   int num_errors, n_checks;
   hdv_timing_gen u_hdv_timing_gen (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pix_y(pix_y), .pix_c(pix_c), .pix_take(pix_take),
      .pix_cr(pix_cr), .out_y(out_y), .out_c(out_c), .out_de(out_de), .out_eav(out_eav),
      .out_href(out_href));
   hdv_rx_model u_hdv_rx_model (.pclk(pclk), .presetn(presetn), .out_y(out_y), .out_de(out_de),
      .out_eav(out_eav), .eav_fvh(eav_fvh), .line_len(line_len), .act_len(act_len),
      .prot_bad(prot_bad));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (num_errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // The answer is taken at the edge where pready is seen high; only the watchdog ends a hang.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_for(input int n, input logic eav);
      int k;
      for (int i = 0; i < n; i++) begin
         k = 0;
         do begin
            @(negedge pclk);
            k++;
         end while ((eav ? out_eav : pix_take) !== 1'b1 && k < 3000);
         if (k >= 3000) chk(32'h0000_0000, 32'h0000_0001);
      end
   endtask
   task automatic t_regs();
      apb(1'b0, `HDV_CTRL_OFS, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      chk({e, q[30:0]}, 32'h8000_0000);
      chk({out_y, out_c}, {`HDV_LVL_BLACK, `HDV_LVL_ACHRO});
   endtask
   // Each family is given three lines so the new setting owns a whole measured line.
   task automatic t_family(input logic [1:0] fam, input logic w8, input logic prog,
                           input logic [11:0] len, input logic [9:0] vmax);
      apb(1'b1, `HDV_CTRL_OFS, {27'h0, prog, fam, w8, 1'b1});
      wait_for(3, 1'b1);
      repeat (8) @(negedge pclk);
      chk(line_len, len);
      chk(act_len, `HDV_ACTIVE);
      chk({prot_bad, eav_fvh}, 4'h3);
      chk({out_y, out_c}, {`HDV_LVL_BLACK, `HDV_LVL_ACHRO});
      wait_for(1, 1'b0);
      chk(pix_cr, 1'b0);
      @(negedge pclk);
      chk({pix_cr, out_de}, 2'h3);
      chk({out_y, out_c}, {vmax, `HDV_LVL_MIN});
   endtask
   task automatic t_status();
      apb(1'b0, `HDV_STAT_OFS, 32'h0000_0000);
      chk(q, 32'h0006_0003);
   endtask
   task automatic t_stop();
      apb(1'b1, `HDV_CTRL_OFS, 32'h0000_0000);
      repeat (3000) @(negedge pclk);
      chk({out_de, out_y, out_c}, {1'b0, `HDV_LVL_BLACK, `HDV_LVL_ACHRO});
      apb(1'b0, `HDV_STAT_OFS, 32'h0000_0000);
      chk(q, 32'h0002_0001);
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      #4_000_000;
      num_errors++;
      close_out();
   end
   initial begin
      presetn    = 1'b0;
      ce         = 1'b1;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 12'h000;
      pwdata     = 32'h0000_0000;
      pix_y      = 10'h3FF;
      pix_c      = 10'h001;
      num_errors = 0;
      n_checks   = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_family(2'h0, 1'b0, 1'b0, `HDV_LEN_60, `HDV_LVL_MAX10);
      t_status();
      t_family(2'h1, 1'b1, 1'b0, `HDV_LEN_50, `HDV_LVL_MAX8);
      t_family(2'h2, 1'b0, 1'b1, `HDV_LEN_24, `HDV_LVL_MAX10);
      t_family(2'h3, 1'b1, 1'b1, `HDV_LEN_60, `HDV_LVL_MAX8);
      t_stop();
      close_out();
   end
endmodule
